// File: inc/e1tx_pkg.sv
// Function
// RULE1 - One transmit config register per channel at 044, 0C4, 144, 1C4; own channel only
// RULE2 - Line code bit one selects AMI, zero selects HDB3
// RULE3 - Both signaling bits zero: timeslot 16 passes backplane PCM unchanged
// RULE4 - Insert off, link select on: timeslot 16 from data-link input
// RULE5 - Both on: timeslot 16 built from backplane signaling or per-channel byte
// RULE6 - Backplane signaling nibble sits in low four bits; link select zero reserved
// RULE7 - CRC enabled: send multiframe alignment, CRC bits, far-end error bits if allowed
// RULE8 - CRC bits of first sub-multiframe after enable are indeterminate
// RULE9 - CRC computed over sub-multiframe n goes out in n+1
// RULE10 - CRC off: CRC positions carry stored bit one; NFAS bit one stored or PCM; code sends PCM bit one in CRC positions when national bits disabled
// RULE11 - Substituted stored or PCM bits go out in the same sub-multiframe
// RULE12 - Framing disable: no pattern in timeslot 0, PCM passes transparently
// RULE13 - Framing on: even frames carry FAS, odd frames carry stored bits
// RULE14 - Framing disabled: CRC, error, national and extra bit settings ignored
// RULE15 - Alarm indication bit forces all ones over everything
// RULE16 - Reset clears config to zero except insert enable and link select set
// RULE17 - National bits from stored register when enabled, else from backplane PCM
// RULE18 - Register changes take effect at the next frame boundary
package e1tx_pkg;

   // ==========================================================
   // Register map, per channel block
   // ==========================================================
   localparam logic [8:0] CH_STRIDE = 9'h080;
   localparam logic [8:0] OFF_CFG = 9'h044;
   localparam logic [8:0] OFF_ALARM = 9'h045;
   localparam logic [8:0] OFF_INTL = 9'h046;
   localparam logic [8:0] OFF_XBITS = 9'h047;
   localparam logic [8:0] OFF_STATUS = 9'h048;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int CFG_AMI_BIT = 7;
   localparam int CFG_SIGNALING_INSERT_ENABLE_BIT = 6;
   localparam int CFG_LINK_SELECT_BIT = 5;
   localparam int CFG_CRC_GENERATE_ENABLE_BIT = 4;
   localparam int CFG_FRAMING_DISABLE_BIT = 3;
   localparam int CFG_FAR_ERROR_INSERT_DISABLE_BIT = 2;
   localparam int CFG_NATIONAL_BITS_DISABLE_BIT = 1;
   localparam int CFG_EXTRA_BITS_DISABLE_BIT = 0;
   localparam logic [7:0] CFG_RESET = 8'h60;
   localparam int ALARM_AIS_BIT = 0;
   localparam int ALARM_RAI_BIT = 1;
   localparam logic [7:0] ALARM_RESET = 8'h00;
   localparam logic [7:0] ALARM_MASK = 8'h03;
   localparam int INTL_SI1_BIT = 7;
   localparam int INTL_SI0_BIT = 6;
   localparam logic [7:0] INTL_RESET = 8'hdf;
   localparam logic [7:0] INTL_MASK = 8'hdf;
   localparam int XB_X1_BIT = 2;
   localparam int XB_X3_BIT = 1;
   localparam int XB_X4_BIT = 0;
   localparam logic [7:0] XBITS_RESET = 8'h07;
   localparam logic [7:0] XBITS_MASK = 8'h07;

   // ==========================================================
   // Frame structure
   // ==========================================================
   localparam logic [6:0] FAS_PATTERN = 7'h1b;
   localparam logic [5:0] MFAS_PATTERN = 6'h0b;
   localparam logic [3:0] CAS_MF_PATTERN = 4'h0;
   localparam logic [4:0] TS_ZERO = 5'h00;
   localparam logic [4:0] TS_SIG = 5'h10;
   localparam logic [4:0] TS_LAST = 5'h1f;
   localparam logic [3:0] CRC_POLY = 4'h3;

   typedef enum logic [3:0] {
      MODE_PASS = 4'b0001,
      MODE_CCS = 4'b0010,
      MODE_RSVD = 4'b0100,
      MODE_CAS = 4'b1000
   } e1tx_mode_type;

   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] alarm;
      logic [7:0] intl;
      logic [7:0] xbits;
   } e1tx_set_type;

   localparam e1tx_set_type SET_RESET = '{CFG_RESET, ALARM_RESET, INTL_RESET, XBITS_RESET};

endpackage

// File: rtl/e1tx_crc4.sv
`timescale 1ns/100ps
module e1tx_crc4 import e1tx_pkg::*; (
   input wire logic sys_clk, // 125 MHz clock
   input wire logic reset_n, // Async reset, active low
   input wire logic enable, // CRC generation active
   input wire logic byte_valid, // One byte of the outgoing frame
   input wire logic [7:0] data_byte, // Byte with CRC positions zeroed
   input wire logic smf_end, // Last byte of a sub-multiframe
   output logic [3:0] crc_bits // Remainder of previous sub-multiframe
);

   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] res;
   } e1tx_crc_type;

   e1tx_crc_type st_ff;
   e1tx_crc_type nxt_st;

   function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [7:0] d);
      logic [3:0] r;
      logic fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[3] ^ d[i];
         r = {r[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
      end
      return r;
   endfunction

   always_comb begin
      nxt_st = st_ff;
      if (!enable) begin
         // Cleared while off; first result after enable is partial
         nxt_st = '0; // see RULE8
      end else if (byte_valid) begin
         if (smf_end) begin
            nxt_st.res = crc_step(st_ff.acc, data_byte); // see RULE9
            nxt_st.acc = 4'h0;
         end else begin
            nxt_st.acc = crc_step(st_ff.acc, data_byte);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign crc_bits = st_ff.res;

endmodule // e1tx_crc4

// File: rtl/e1tx_frame_cfg.sv
`timescale 1ns/100ps
module e1tx_frame_cfg import e1tx_pkg::*; #(
   parameter int NUM_CHANNELS = 4,
   parameter int CHANNEL = 0
) (
   input wire logic sys_clk, // 125 MHz clock
   input wire logic reset_n, // Async reset, active low
   input wire logic [8:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic bp_valid, // One timeslot byte presented
   input wire logic mf_sync, // Byte is TS0 of multiframe frame 0
   input wire logic [7:0] backplane_tx_pcm, // Backplane PCM byte
   input wire logic [7:0] backplane_tx_signaling, // Backplane signaling byte
   input wire logic [7:0] tx_datalink_input, // Common-channel byte for TS16
   input wire logic signaling_source_select, // 1: take per-channel nibble
   input wire logic [3:0] tx_per_channel_controller, // Per-channel signaling nibble
   input wire logic [1:0] far_error_bits, // Far-end error bits, frames 13 and 15
   output logic line_valid, // Output byte valid
   output logic [7:0] line_byte, // Byte to line encoder, bit 1 is MSB
   output logic line_code_ami // 1: AMI, 0: HDB3
);

   generate
      if (CHANNEL < 0 || CHANNEL >= NUM_CHANNELS || NUM_CHANNELS > 4) begin : g_bad
         $error("e1tx_frame_cfg: channel index out of range");
      end
   endgenerate

   // Base of this channel's register block
   localparam logic [8:0] CH_BASE = 9'(CHANNEL * CH_STRIDE);

   typedef struct packed {
      e1tx_set_type live;
      e1tx_set_type act;
      logic [4:0] ts;
      logic [3:0] frm;
      logic [31:0][3:0] sig;
      logic [7:0] out_byte;
      logic out_valid;
      logic [7:0] rdata;
      logic ami;
   } e1tx_state_type;

   localparam e1tx_state_type ST_RESET = '{SET_RESET, SET_RESET, 5'h00, 4'h0, '0,
                                           8'h00, 1'b0, 8'h00, 1'b0};

   e1tx_state_type st_ff;
   e1tx_state_type nxt_st;
   e1tx_set_type s;
   e1tx_mode_type mode;
   logic [4:0] ts_cur;
   logic [3:0] frm_cur;
   logic [7:0] built;
   logic [7:0] crc_feed;
   logic [3:0] crc_bits;
   logic crc_on;
   logic smf_end;

   function automatic e1tx_mode_type ts16_mode(input logic [7:0] cfg);
      case ({cfg[CFG_SIGNALING_INSERT_ENABLE_BIT], cfg[CFG_LINK_SELECT_BIT]})
         2'b00: return MODE_PASS;
         2'b01: return MODE_CCS;
         2'b10: return MODE_RSVD;
         default: return MODE_CAS;
      endcase
   endfunction

   function automatic logic own_reg(input logic [8:0] addr, input logic [8:0] off);
      return addr == (CH_BASE + off); // see RULE1
   endfunction

   // ==========================================================
   // Position in the multiframe
   // ==========================================================
   assign ts_cur = mf_sync ? TS_ZERO : st_ff.ts;
   assign frm_cur = mf_sync ? 4'h0 : st_ff.frm;

   // New settings only at TS0 so one frame never mixes two configurations
   assign s = (ts_cur == TS_ZERO) ? st_ff.live : st_ff.act; // see RULE18
   assign mode = ts16_mode(s.cfg);
   assign crc_on = s.cfg[CFG_CRC_GENERATE_ENABLE_BIT] & ~s.cfg[CFG_FRAMING_DISABLE_BIT]; // see RULE14
   assign smf_end = (ts_cur == TS_LAST) && (frm_cur[2:0] == 3'h7);

   // ==========================================================
   // Byte assembly
   // ==========================================================
   always_comb begin
      logic [7:0] pcm;
      logic national_bits_disable;
      logic extra_bits_disable;
      logic bit1;
      pcm = backplane_tx_pcm;
      national_bits_disable = s.cfg[CFG_NATIONAL_BITS_DISABLE_BIT];
      extra_bits_disable = s.cfg[CFG_EXTRA_BITS_DISABLE_BIT];
      bit1 = pcm[7];
      built = pcm;
      crc_feed = pcm;
      if (ts_cur == TS_ZERO) begin
         if (s.cfg[CFG_FRAMING_DISABLE_BIT]) begin
            built = pcm; // see RULE12
         end else if (!frm_cur[0]) begin
            // FAS frame: bit 1 is a CRC bit or its substitute
            if (crc_on) begin
               bit1 = crc_bits[3 - frm_cur[2:1]]; // see RULE7
            end else if (national_bits_disable) begin
               bit1 = pcm[7]; // see RULE11
            end else begin
               bit1 = s.intl[INTL_SI1_BIT]; // see RULE10
            end
            built = {bit1, FAS_PATTERN}; // see RULE13
            crc_feed = {1'b0, FAS_PATTERN};
         end else begin
            if (crc_on) begin
               if (frm_cur < 4'hc) begin
                  bit1 = MFAS_PATTERN[5 - frm_cur[3:1]]; // see RULE7
               end else if (!s.cfg[CFG_FAR_ERROR_INSERT_DISABLE_BIT]) begin
                  bit1 = far_error_bits[frm_cur[1] ? 0 : 1]; // see RULE7
               end else begin
                  bit1 = frm_cur[1] ? s.intl[INTL_SI0_BIT] : s.intl[INTL_SI1_BIT];
               end
            end else begin
               bit1 = national_bits_disable ? pcm[7] : s.intl[INTL_SI0_BIT]; // see RULE10
            end
            built[7] = bit1;
            built[6] = 1'b1;
            built[5] = s.alarm[ALARM_RAI_BIT];
            built[4:0] = national_bits_disable ? pcm[4:0] : s.intl[4:0]; // see RULE17
            crc_feed = built;
         end
      end else if (ts_cur == TS_SIG) begin
         case (mode)
            MODE_PASS: built = pcm; // see RULE3
            MODE_CCS: built = tx_datalink_input; // see RULE4
            MODE_RSVD: built = pcm;
            MODE_CAS: begin
               if (frm_cur == 4'h0) begin
                  built = {CAS_MF_PATTERN, s.intl[7:4]};
                  if (extra_bits_disable || s.cfg[CFG_FRAMING_DISABLE_BIT]) begin
                     built[3:0] = {pcm[3], 1'b0, pcm[1:0]}; // see RULE14
                  end else begin
                     built[3:0] = {s.xbits[XB_X1_BIT], 1'b0, s.xbits[XB_X3_BIT],
                                   s.xbits[XB_X4_BIT]};
                  end
               end else begin
                  built = {st_ff.sig[frm_cur], st_ff.sig[{1'b1, frm_cur}]}; // see RULE5
               end
            end
            default: built = pcm;
         endcase
         crc_feed = built;
      end else begin
         crc_feed = pcm;
      end
      if (s.alarm[ALARM_AIS_BIT]) begin
         built = 8'hff; // see RULE15
         crc_feed = 8'hff;
      end
   end

   e1tx_crc4 u_crc4 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .enable(crc_on),
      .byte_valid(bp_valid),
      .data_byte(crc_feed),
      .smf_end(smf_end),
      .crc_bits(crc_bits)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      nxt_st = st_ff;
      nxt_st.out_valid = bp_valid;
      nxt_st.rdata = 8'h00;
      if (bp_valid) begin
         nxt_st.out_byte = built;
         nxt_st.ts = ts_cur + 5'h01;
         nxt_st.frm = (ts_cur == TS_LAST) ? frm_cur + 4'h1 : frm_cur;
         if (ts_cur == TS_ZERO) begin
            nxt_st.act = st_ff.live; // see RULE18
         end
         if (ts_cur != TS_ZERO && ts_cur != TS_SIG) begin
            // Only the low nibble carries signaling
            nxt_st.sig[ts_cur] = signaling_source_select ? tx_per_channel_controller
                                 : backplane_tx_signaling[3:0]; // see RULE6
         end
      end
      // Line code switches together with the TS0 byte that first uses the new settings
      if (bp_valid && ts_cur == TS_ZERO) begin
         nxt_st.ami = st_ff.live.cfg[CFG_AMI_BIT]; // see RULE2
      end else begin
         nxt_st.ami = st_ff.act.cfg[CFG_AMI_BIT]; // see RULE2
      end
      if (reg_wr) begin
         if (own_reg(reg_addr, OFF_CFG)) begin
            nxt_st.live.cfg = reg_wdata;
         end else if (own_reg(reg_addr, OFF_ALARM)) begin
            nxt_st.live.alarm = reg_wdata & ALARM_MASK;
         end else if (own_reg(reg_addr, OFF_INTL)) begin
            nxt_st.live.intl = reg_wdata & INTL_MASK;
         end else if (own_reg(reg_addr, OFF_XBITS)) begin
            nxt_st.live.xbits = reg_wdata & XBITS_MASK;
         end
      end
      if (reg_rd) begin
         if (own_reg(reg_addr, OFF_CFG)) begin
            nxt_st.rdata = st_ff.live.cfg;
         end else if (own_reg(reg_addr, OFF_ALARM)) begin
            nxt_st.rdata = st_ff.live.alarm;
         end else if (own_reg(reg_addr, OFF_INTL)) begin
            nxt_st.rdata = st_ff.live.intl;
         end else if (own_reg(reg_addr, OFF_XBITS)) begin
            nxt_st.rdata = st_ff.live.xbits;
         end else if (own_reg(reg_addr, OFF_STATUS)) begin
            nxt_st.rdata = {2'b00, st_ff.act.cfg[CFG_CRC_GENERATE_ENABLE_BIT] & ~st_ff.act.cfg[CFG_FRAMING_DISABLE_BIT],
                            st_ff.ts == TS_ZERO, st_ff.frm};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= ST_RESET; // see RULE16
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign line_valid = st_ff.out_valid;
   assign line_byte = st_ff.out_byte;
   assign line_code_ami = st_ff.ami;

endmodule // e1tx_frame_cfg

// File: tb/e1tx_frame_cfg_sva.sv
`timescale 1ns/100ps
module e1tx_frame_cfg_sva import e1tx_pkg::*; #(
   parameter int NUM_CHANNELS = 4,
   parameter int CHANNEL = 0
) (
   input wire logic sys_clk, // Clock
   input wire logic reset_n, // Reset, active low
   input wire logic [8:0] reg_addr, // Address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic bp_valid, // Byte in
   input wire logic mf_sync, // Multiframe start
   input wire logic [7:0] backplane_tx_pcm, // PCM in
   input wire logic [7:0] tx_datalink_input, // CCS byte
   input wire logic line_valid, // Byte out
   input wire logic [7:0] line_byte, // Line byte
   input wire logic line_code_ami // Line code
);
   // ======
   // Shadow of the settings in force
   // ======
   localparam logic [8:0] BASE = 9'(CHANNEL * 128);
   logic [4:0] ts_ff;
   logic [3:0] frm_ff;
   logic [7:0] cfg_sh_ff;
   logic [7:0] cfg_act_ff;
   logic ais_sh_ff;
   logic ais_act_ff;
   logic pos0;
   logic is16;
   logic ais_eff;
   logic [7:0] cfg_eff;
   assign pos0 = mf_sync || ts_ff == TS_ZERO;
   assign is16 = !mf_sync && ts_ff == TS_SIG;
   // The TS0 byte already uses the new settings
   assign cfg_eff = pos0 ? cfg_sh_ff : cfg_act_ff;
   assign ais_eff = pos0 ? ais_sh_ff : ais_act_ff;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ts_ff <= TS_ZERO;
         frm_ff <= 4'h0;
         cfg_sh_ff <= CFG_RESET;
         cfg_act_ff <= CFG_RESET;
         ais_sh_ff <= 1'b0;
         ais_act_ff <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == BASE + OFF_CFG) begin
            cfg_sh_ff <= reg_wdata;
         end
         if (reg_wr && reg_addr == BASE + OFF_ALARM) begin
            ais_sh_ff <= reg_wdata[ALARM_AIS_BIT];
         end
         if (bp_valid) begin
            ts_ff <= mf_sync ? 5'h01 : ts_ff + 5'h01;
            frm_ff <= mf_sync ? 4'h0 : frm_ff + 4'(ts_ff == TS_LAST);
            if (pos0) begin
               cfg_act_ff <= cfg_sh_ff;
               ais_act_ff <= ais_sh_ff;
            end
         end
      end
   end
   // ======
   // Properties
   // ======
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_live;
      bp_valid && !ais_eff;
   endsequence
   AST_LINE_LAT: assert property (line_valid == $past(bp_valid))
      else $error("line byte not one cycle after input byte");
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   AST_RD_FOREIGN: assert property (reg_rd && reg_addr[8:7] != 2'(CHANNEL) |=> !reg_rdata)
      else $error("other channel address answered");
   AST_AIS_ONES: assert property (bp_valid && ais_eff |=> line_byte == 8'hff)
      else $error("alarm byte not all ones");
   AST_TRANSP: assert property (s_live ##0 (cfg_eff[CFG_FRAMING_DISABLE_BIT] && !is16)
      |=> line_byte == $past(backplane_tx_pcm)) else $error("unframed byte altered");
   AST_TS16_PASS: assert property (s_live ##0 (is16 && cfg_eff[6:5] == 2'b00)
      |=> line_byte == $past(backplane_tx_pcm)) else $error("TS16 not passed");
   AST_TS16_CCS: assert property (s_live ##0 (is16 && cfg_eff[6:5] == 2'b01)
      |=> line_byte == $past(tx_datalink_input)) else $error("TS16 not data link");
   AST_FAS: assert property (s_live ##0 (pos0 && !(!mf_sync && frm_ff[0])
      && !cfg_eff[CFG_FRAMING_DISABLE_BIT]) |=> line_byte[6:0] == FAS_PATTERN) else $error("no FAS");
   AST_AMI: assert property (bp_valid && pos0 |=> line_code_ami == cfg_act_ff[CFG_AMI_BIT])
      else $error("line code differs from setting");
   AST_AMI_HOLD: assert property (!(bp_valid && pos0) |=> $stable(line_code_ami))
      else $error("line code changed mid frame");
endmodule // e1tx_frame_cfg_sva

bind e1tx_frame_cfg e1tx_frame_cfg_sva #(.NUM_CHANNELS(NUM_CHANNELS), .CHANNEL(CHANNEL)) u_sva (.*);

// File: tb/e1tx_bp_source.sv
`timescale 1ns/100ps
module e1tx_bp_source (
   input wire logic sys_clk, // Clock
   input wire logic reset_n, // Reset, active low
   input wire logic run, // Stream enable
   input wire logic slow, // Insert idle gaps
   input wire logic [3:0] nib, // Signaling nibble
   output logic bp_valid, // Byte presented
   output logic mf_sync, // Multiframe start
   output logic [7:0] pcm, // PCM byte
   output logic [7:0] sig, // Signaling byte
   output logic [7:0] dl // Data link byte
);
   int pos;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pos = 0;
         bp_valid <= 1'b0;
         mf_sync <= 1'b0;
         pcm <= 8'h00;
         sig <= 8'h00;
         dl <= 8'h00;
      end else if (run && !(slow && $urandom_range(2) == 0)) begin
         bp_valid <= 1'b1;
         mf_sync <= pos == 0;
         pcm <= 8'($urandom);
         sig <= {4'($urandom), nib};
         dl <= 8'($urandom);
         pos = (pos + 1) % 512;
      end else begin
         // Idle lines flip so stale data never looks valid
         bp_valid <= 1'b0;
         mf_sync <= 1'b0;
         pcm <= ~pcm;
         sig <= ~sig;
         dl <= ~dl;
      end
   end
endmodule // e1tx_bp_source

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench import e1tx_pkg::*; ;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [8:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, line_byte, pcm, sig, dl, exp_b, exp_m, d;
   logic line_valid, line_code_ami, bp_valid, mf_sync;
   logic sel = 1'b0;
   logic run = 1'b0;
   logic slow = 1'b0;
   logic chk = 1'b0;
   logic exp_on = 1'b0;
   logic [3:0] nib = 4'h0;
   logic [1:0] feb = 2'b00;
   logic [7:0] cfg = CFG_RESET;
   logic [7:0] alarm = 8'h00;
   logic [7:0] intl = INTL_RESET;
   logic [7:0] xb = XBITS_RESET;
   int err_total = 0;
   int total_checks = 0;
   int nbytes = 0;
   int ts = 0;
   int frm = 0;
   logic [3:0] crc_acc = 4'h0;
   logic [3:0] crc_res = 4'h0;
   logic crc_full = 1'b0;
   logic crc_ok = 1'b0;
   // Link select stays set whenever insertion is on
   logic [7:0] cfgs [11] = '{8'h08, 8'h00, 8'h20, 8'h80, 8'h60, 8'h61, 8'h68, 8'h10, 8'h14,
      8'h1b, 8'h02};

   e1tx_frame_cfg u_e1tx_frame_cfg (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bp_valid(bp_valid), .mf_sync(mf_sync), .backplane_tx_pcm(pcm),
      .backplane_tx_signaling(sig), .tx_datalink_input(dl), .signaling_source_select(sel),
      .tx_per_channel_controller(nib), .far_error_bits(feb), .line_valid(line_valid),
      .line_byte(line_byte), .line_code_ami(line_code_ami));
   e1tx_bp_source u_e1tx_bp_source (.sys_clk(sys_clk), .reset_n(reset_n), .run(run),
      .slow(slow), .nib(~nib), .bp_valid(bp_valid), .mf_sync(mf_sync), .pcm(pcm), .sig(sig),
      .dl(dl));

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // ======
   // Reference model
   // ======
   // Remainder MSB is the first CRC bit
   function automatic logic [3:0] crc_byte(input logic [3:0] c, input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? CRC_POLY : 4'h0);
      end
      return c;
   endfunction

   function automatic logic [7:0] model(input int t, input int f, input logic [7:0] p,
      output logic [7:0] m);
      logic [7:0] b;
      logic i1;
      m = 8'hff;
      b = p;
      if (t == 0 && !cfg[3]) begin
         if (f % 2 == 0) begin
            b = {cfg[1] ? p[7] : intl[7], FAS_PATTERN};
            if (cfg[4]) begin
               b[7] = crc_res[3 - (f % 8) / 2];
               // Only a sub-multiframe summed whole since enable is predictable
               m = crc_ok ? 8'hff : 8'h7f;
            end
         end else begin
            i1 = cfg[1] ? p[7] : intl[6];
            if (cfg[4]) begin
               i1 = f < 12 ? MFAS_PATTERN[5 - f / 2] :
                  (cfg[2] ? intl[f == 13 ? 7 : 6] : feb[f == 13 ? 1 : 0]);
            end
            b = {i1, 1'b1, alarm[1], cfg[1] ? p[4:0] : intl[4:0]};
         end
      end else if (t == 16 && cfg[6:5] == 2'b01) begin
         b = dl;
      end else if (t == 16 && cfg[6:5] == 2'b11) begin
         b = sel ? {nib, nib} : {~nib, ~nib};
         if (f == 0) begin
            b = (cfg[0] || cfg[3]) ? {4'h0, p[3], 1'b0, p[1:0]} : {4'h0, xb[2], 1'b0, xb[1:0]};
         end
      end
      return alarm[0] ? 8'hff : b;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      total_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      exp_on = bp_valid && chk;
      if (bp_valid) begin
         ts = mf_sync ? 0 : ts;
         frm = mf_sync ? 0 : frm;
         exp_b = model(ts, frm, pcm, exp_m);
         if (!cfg[4] || cfg[3]) begin
            crc_full = 1'b0;
            crc_ok = 1'b0;
         end else begin
            if (ts == 0 && frm % 8 == 0) begin
               crc_full = 1'b1;
               crc_acc = 4'h0;
            end
            crc_acc = crc_byte(crc_acc, (ts == 0 && frm % 2 == 0 && !alarm[0]) ?
               {1'b0, exp_b[6:0]} : exp_b);
            if (ts == 31 && frm % 8 == 7) begin
               crc_res = crc_acc;
               crc_ok = crc_full;
            end
         end
         frm = ts == 31 ? (frm + 1) % 16 : frm;
         ts = (ts + 1) % 32;
         nbytes++;
      end
   end

   always @(negedge sys_clk) begin
      if (exp_on) begin
         check(line_byte & exp_m, exp_b & exp_m);
         check({7'h0, line_code_ami}, {7'h0, cfg[7]});
      end
   end

   // ======
   // Bus and stream tasks
   // ======
   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [8:0] a, input logic [7:0] want);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      check(reg_rdata, want);
   endtask

   task automatic wait_bytes(input int n);
      int stop;
      stop = nbytes + n;
      for (int i = 0; i < 8 * n && nbytes < stop; i++) @(posedge sys_clk);
      if (nbytes < stop) begin
         err_total++;
         complete_run();
      end
   endtask

   // Stream paused while writing so no byte meets a half-written setting
   task automatic run_cfg(input logic [7:0] c, input logic [7:0] al);
      chk = 1'b0;
      run <= 1'b0;
      @(posedge sys_clk);
      wr(OFF_CFG, c);
      wr(OFF_ALARM, al);
      cfg = c;
      alarm = al;
      rd_chk(OFF_CFG, c);
      rd_chk(OFF_ALARM, al);
      run <= 1'b1;
      wait_bytes(40);
      chk = 1'b1;
      wait_bytes(512);
      $display("test cfg=%h alarm=%h done", c, al);
   endtask

   initial begin
      void'($urandom(32'h3ed6423c));
      nib = 4'($urandom);
      feb = 2'($urandom);
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd_chk(OFF_CFG, CFG_RESET);
      rd_chk(OFF_ALARM, ALARM_RESET);
      rd_chk(OFF_INTL, INTL_RESET);
      rd_chk(OFF_XBITS, XBITS_RESET);
      wr(OFF_CFG + CH_STRIDE, 8'h9f);
      rd_chk(OFF_CFG + CH_STRIDE, 8'h00);
      rd_chk(OFF_CFG, CFG_RESET);
      rd_chk(9'h049, 8'h00);
      d = 8'($urandom);
      wr(OFF_INTL, d);
      intl = d & INTL_MASK;
      rd_chk(OFF_INTL, intl);
      d = 8'($urandom);
      wr(OFF_XBITS, d);
      xb = d & XBITS_MASK;
      rd_chk(OFF_XBITS, xb);
      $display("register test done");
      foreach (cfgs[i]) begin
         sel <= i[0];
         slow <= i[1];
         run_cfg(cfgs[i], 8'h00);
      end
      run_cfg(8'h60, 8'h01);
      run_cfg(8'h00, 8'h02);
      complete_run();
   end
endmodule // testbench
